// [common/fppc_pkg.sv]
package fppc_pkg;

	// ****************************************
	// Widths and register offsets
	// ****************************************
	localparam int          DATA_W       = 16;
	localparam int          ADDR_W       = 16;
	localparam logic [15:0] ADDR_REVISION = 16'h8005;
	localparam logic [15:0] ADDR_PART_ID  = 16'h8006;
	localparam logic [15:0] ADDR_CFG_WP   = 16'h800A;
	localparam logic [15:0] ADDR_CFG_CP   = 16'h800B;
	localparam logic [15:0] ADDR_STATUS   = 16'h8010;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_LVP        = 13;
	localparam int BIT_SAF_LOCK   = 11;
	localparam int BIT_EE_LOCK    = 10;
	localparam int BIT_CFG_LOCK   = 9;
	localparam int BIT_BOOT_LOCK  = 8;
	localparam int BIT_APP_LOCK   = 7;
	localparam int BIT_SAF_EN     = 4;
	localparam int BIT_BOOT_EN    = 3;
	localparam int BIT_SIZE_HI    = 2;
	localparam int BIT_SIZE_LO    = 0;
	localparam int BIT_EE_GUARD   = 1;
	localparam int BIT_PROG_GUARD = 0;
	localparam int BIT_ERR        = 0;
	localparam int BIT_LVP_SES    = 1;

	// ****************************************
	// Erased values and masks
	// ****************************************
	localparam logic [15:0] CFG_WP_ERASED = 16'h2F9F;
	localparam logic [15:0] CFG_WP_STICKY = 16'h0F98;
	localparam logic [15:0] CFG_CP_ERASED = 16'h0003;
	localparam logic [1:0]  ID_TOP_PART   = 2'h3;
	localparam logic [1:0]  ID_TOP_REV    = 2'h2;

	// ****************************************
	// Memory map
	// ****************************************
	localparam logic [15:0] PROG_LAST    = 16'h1FFF;
	localparam logic [15:0] BOOT_MAX_END = 16'h0FFF;
	localparam logic [15:0] SAF_BASE     = 16'h1F80;
	localparam logic [15:0] CFG_LO       = 16'h8000;
	localparam logic [15:0] CFG_HI       = 16'h800F;
	localparam logic [15:0] EE_LO        = 16'hF000;
	localparam logic [15:0] EE_HI        = 16'hF0FF;
	localparam logic [15:0] BOOT_END_512 = 16'h01FF;
	localparam logic [15:0] BOOT_END_1K  = 16'h03FF;
	localparam logic [15:0] BOOT_END_2K  = 16'h07FF;
	localparam logic [15:0] BOOT_END_4K  = 16'h0FFF;
	localparam logic [15:0] BOOT_END_8K  = 16'h1FFF;
	localparam logic [15:0] BOOT_END_16K = 16'h3FFF;

	typedef enum logic [2:0] {FPPC_RGN_BOOT, FPPC_RGN_APP, FPPC_RGN_SAF, FPPC_RGN_CFG, FPPC_RGN_EE,
		FPPC_RGN_NONE} fppc_region_t;

endpackage

// [core/fppc_core.sv]
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
module fppc_core #(
	parameter logic [11:0] PART_CODE = 12'hA5C,	// Arbitrary value
	parameter logic [5:0]  MAJOR_REV = 6'h01,	// Arbitrary value
	parameter logic [5:0]  MINOR_REV = 6'h02	// Arbitrary value
) (
	input  wire logic                        clk_sys,
	input  wire logic                        reset_n,
	input  wire logic [fppc_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [fppc_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [fppc_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic [fppc_pkg::DATA_W-1:0] cfg_wp_image,
	input  wire logic [fppc_pkg::DATA_W-1:0] cfg_cp_image,
	input  wire logic                        bulk_erase,
	input  wire logic                        lvp_session,
	input  wire logic                        nvm_wr_req,
	input  wire logic [fppc_pkg::ADDR_W-1:0] nvm_wr_addr,
	output logic                             nvm_wr_grant,
	output logic                             nvm_wr_refused,
	input  wire logic                        fetch_req,
	input  wire logic [fppc_pkg::ADDR_W-1:0] fetch_addr,
	output logic                             exec_violation,
	output logic                             write_error_flag,
	output logic                             boot_region_active,
	output logic      [fppc_pkg::ADDR_W-1:0] boot_end_addr,
	output logic                             storage_area_active,
	output logic                             program_guard_on,
	output logic                             eeprom_guard_on
);
	import fppc_pkg::*;

	// ****************************************
	// Helper functions
	// ****************************************

	// Boot end address from the size field, clamped to half memory
	function automatic logic [15:0] boot_end_of(input logic [2:0] sel);
		logic [15:0] raw;
		case (sel)
			3'h7:    raw = BOOT_END_512;
			3'h6:    raw = BOOT_END_1K;
			3'h5:    raw = BOOT_END_2K;
			3'h4:    raw = BOOT_END_4K;
			3'h3:    raw = BOOT_END_8K;
			default: raw = BOOT_END_16K;
		endcase
		boot_end_of = (raw > BOOT_MAX_END) ? BOOT_MAX_END : raw;
	endfunction

	// Region that an address falls in under a given partition
	function automatic fppc_region_t region_of(input logic [15:0] a, input logic boot_en_n,
		input logic [15:0] boot_end, input logic saf_en_n);
		if (a <= PROG_LAST) begin
			if (!boot_en_n && (a <= boot_end))
				region_of = FPPC_RGN_BOOT;
			else if (!saf_en_n && (a >= SAF_BASE))
				region_of = FPPC_RGN_SAF;
			else
				region_of = FPPC_RGN_APP;
		end else if ((a >= CFG_LO) && (a <= CFG_HI))
			region_of = FPPC_RGN_CFG;
		else if ((a >= EE_LO) && (a <= EE_HI))
			region_of = FPPC_RGN_EE;
		else
			region_of = FPPC_RGN_NONE;
	endfunction

	// ****************************************
	// State
	// ****************************************
	logic [15:0]  cfg_wp;
	logic [15:0]  cfg_cp;
	logic         load_pending;
	logic         act_boot_en_n;
	logic         act_saf_en_n;
	logic [2:0]   act_size;
	logic         lvp_meta;
	logic         lvp_sync;
	logic [15:0]  act_boot_end;

	// ****************************************
	// Low voltage session pin synchroniser
	// ****************************************

	// Asynchronous pin, two flops before any use
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			lvp_meta <= 1'b0;
			lvp_sync <= 1'b0;
		end else begin
			lvp_meta <= lvp_session;
			lvp_sync <= lvp_meta;
		end
	end

	// ****************************************
	// Configuration write decode
	// ****************************************
	wire          hit_wp      = reg_wr && (reg_addr == ADDR_CFG_WP);
	wire          hit_cp      = reg_wr && (reg_addr == ADDR_CFG_CP);
	wire          hit_status  = reg_wr && (reg_addr == ADDR_STATUS);
	wire          cfg_unlock  = cfg_wp[BIT_CFG_LOCK];
	wire          cfg_refused = (hit_wp || hit_cp) && !cfg_unlock;
	wire [15:0]   wp_req      = reg_wdata & CFG_WP_ERASED;
	// Lock bits and the boot and storage area enables may only fall; a one never restores them
	wire [15:0]   wp_sticky   = cfg_wp & wp_req & CFG_WP_STICKY;
	// Size is frozen once the boot region is enabled
	wire [2:0]    size_new    = cfg_wp[BIT_BOOT_EN] ? wp_req[BIT_SIZE_HI:BIT_SIZE_LO]
		: cfg_wp[BIT_SIZE_HI:BIT_SIZE_LO];
	// Keeps the programmer from locking itself out mid session
	wire          lvp_new     = (lvp_sync && !wp_req[BIT_LVP]) ? cfg_wp[BIT_LVP] : wp_req[BIT_LVP];
	wire [15:0]   wp_written  = wp_sticky | (16'(lvp_new) << BIT_LVP) | {13'h0000, size_new};
	wire [15:0]   cp_written  = cfg_cp & reg_wdata & CFG_CP_ERASED;

	// Configuration words: erase wins, then image load, then writes
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			cfg_wp <= CFG_WP_ERASED;
			cfg_cp <= CFG_CP_ERASED;
		end else if (bulk_erase) begin
			cfg_wp <= CFG_WP_ERASED;
			cfg_cp <= CFG_CP_ERASED;
		end else if (load_pending) begin
			cfg_wp <= cfg_wp_image & CFG_WP_ERASED;
			cfg_cp <= cfg_cp_image & CFG_CP_ERASED;
		end else if (cfg_unlock) begin
			if (hit_wp)
				cfg_wp <= wp_written;
			if (hit_cp)
				cfg_cp <= cp_written;
		end
	end

	// ****************************************
	// Partition capture
	// ****************************************

	// Partition is taken once after reset so regions never move under running code
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			load_pending  <= 1'b1;
			act_boot_en_n <= 1'b1;
			act_saf_en_n  <= 1'b1;
			act_size      <= 3'h7;
		end else begin
			load_pending <= 1'b0;
			if (load_pending) begin
				act_boot_en_n <= cfg_wp_image[BIT_BOOT_EN];
				act_saf_en_n  <= cfg_wp_image[BIT_SAF_EN];
				act_size      <= cfg_wp_image[BIT_SIZE_HI:BIT_SIZE_LO];
			end
		end
	end

	assign act_boot_end = boot_end_of(act_size);

	// ****************************************
	// Write permission and execution check
	// ****************************************
	fppc_region_t wr_region;
	fppc_region_t fetch_region;
	logic         wr_allowed;

	// Disabled regions fold into application space through the decode
	assign wr_region    = region_of(nvm_wr_addr, act_boot_en_n, act_boot_end, act_saf_en_n);
	assign fetch_region = region_of(fetch_addr, act_boot_en_n, act_boot_end, act_saf_en_n);

	// Locks are read live so a new protection bites at once
	always_comb begin
		case (wr_region)
			FPPC_RGN_BOOT: wr_allowed = cfg_wp[BIT_BOOT_LOCK];
			FPPC_RGN_APP:  wr_allowed = cfg_wp[BIT_APP_LOCK];
			FPPC_RGN_SAF:  wr_allowed = cfg_wp[BIT_SAF_LOCK];
			FPPC_RGN_CFG:  wr_allowed = cfg_wp[BIT_CFG_LOCK];
			FPPC_RGN_EE:   wr_allowed = cfg_wp[BIT_EE_LOCK];
			default:       wr_allowed = 1'b0;
		endcase
	end

	wire wr_refuse  = nvm_wr_req && !wr_allowed;
	wire err_set    = wr_refuse || cfg_refused;
	wire err_clear  = hit_status && reg_wdata[BIT_ERR];

	// Grant or refusal, one cycle after the request
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			nvm_wr_grant   <= 1'b0;
			nvm_wr_refused <= 1'b0;
			exec_violation <= 1'b0;
		end else begin
			nvm_wr_grant   <= nvm_wr_req && wr_allowed;
			nvm_wr_refused <= wr_refuse;
			exec_violation <= fetch_req && (fetch_region == FPPC_RGN_SAF);
		end
	end

	// Sticky error flag; a new error beats a clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			write_error_flag <= 1'b0;
		else if (err_set)
			write_error_flag <= 1'b1;
		else if (err_clear)
			write_error_flag <= 1'b0;
	end

	// ****************************************
	// Policy outputs
	// ****************************************

	// Registered copies for the surrounding memory logic
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			boot_region_active  <= 1'b0;
			boot_end_addr       <= 16'h0000;
			storage_area_active <= 1'b0;
			program_guard_on    <= 1'b0;
			eeprom_guard_on     <= 1'b0;
		end else begin
			boot_region_active  <= !act_boot_en_n;
			boot_end_addr       <= act_boot_en_n ? 16'h0000 : act_boot_end;
			storage_area_active <= !act_saf_en_n;
			program_guard_on    <= !cfg_cp[BIT_PROG_GUARD];
			eeprom_guard_on     <= !cfg_cp[BIT_EE_GUARD];
		end
	end

	// ****************************************
	// Register read
	// ****************************************
	wire [15:0] part_word   = {2'h0, ID_TOP_PART, PART_CODE};
	wire [15:0] rev_word    = {2'h0, ID_TOP_REV, MAJOR_REV, MINOR_REV};
	wire [15:0] status_word = 16'(write_error_flag) << BIT_ERR | 16'(lvp_sync) << BIT_LVP_SES;
	wire [15:0] next_rdata  = !reg_rd ? 16'h0000 :
		(reg_addr == ADDR_PART_ID)  ? part_word :
		(reg_addr == ADDR_REVISION) ? rev_word :
		(reg_addr == ADDR_CFG_WP)   ? cfg_wp :
		(reg_addr == ADDR_CFG_CP)   ? cfg_cp :
		(reg_addr == ADDR_STATUS)   ? status_word : 16'h0000;

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			reg_rdata <= 16'h0000;
		else
			reg_rdata <= next_rdata;
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	wire quiet = !bulk_erase && !load_pending;

	property p_saf_lock;
		nvm_wr_req && (wr_region == FPPC_RGN_SAF) && !cfg_wp[BIT_SAF_LOCK] |=> nvm_wr_refused && !nvm_wr_grant;
	endproperty
	a_saf_lock: assert property (p_saf_lock) else $error("storage area write not refused");

	property p_ee_lock;
		nvm_wr_req && (wr_region == FPPC_RGN_EE) |=> nvm_wr_grant == $past(cfg_wp[BIT_EE_LOCK]);
	endproperty
	a_ee_lock: assert property (p_ee_lock) else $error("eeprom grant disagrees with lock");

	property p_cfg_lock;
		quiet && (hit_wp || hit_cp) && !cfg_unlock |=> $stable(cfg_wp) && $stable(cfg_cp) && write_error_flag;
	endproperty
	a_cfg_lock: assert property (p_cfg_lock) else $error("locked configuration changed");

	property p_boot_lock;
		nvm_wr_req && !act_boot_en_n && (nvm_wr_addr <= act_boot_end) && !cfg_wp[BIT_BOOT_LOCK]
			|=> nvm_wr_refused;
	endproperty
	a_boot_lock: assert property (p_boot_lock) else $error("boot write not refused");

	property p_app_lock;
		nvm_wr_req && (wr_region == FPPC_RGN_APP) && cfg_wp[BIT_APP_LOCK] |=> nvm_wr_grant && !nvm_wr_refused;
	endproperty
	a_app_lock: assert property (p_app_lock) else $error("open application write refused");

	property p_saf_off;
		act_saf_en_n && nvm_wr_req && (nvm_wr_addr >= SAF_BASE) && (nvm_wr_addr <= PROG_LAST)
			|=> nvm_wr_grant == $past(cfg_wp[BIT_APP_LOCK]);
	endproperty
	a_saf_off: assert property (p_saf_off) else $error("disabled storage area not application");

	property p_boot_half;
		boot_region_active |-> (boot_end_addr <= BOOT_MAX_END) && (boot_end_addr != 16'h0000);
	endproperty
	a_boot_half: assert property (p_boot_half) else $error("boot end beyond half memory");

	property p_size_frozen;
		quiet && !cfg_wp[BIT_BOOT_EN] |=> $stable(cfg_wp[BIT_SIZE_HI:BIT_SIZE_LO]);
	endproperty
	a_size_frozen: assert property (p_size_frozen) else $error("size changed while boot enabled");

	property p_sticky;
		quiet |=> ((cfg_wp & CFG_WP_STICKY & ~$past(cfg_wp)) == 16'h0000);
	endproperty
	a_sticky: assert property (p_sticky) else $error("protection bit released");

	property p_lvp_keep;
		quiet && lvp_sync && hit_wp && !reg_wdata[BIT_LVP] |=> $stable(cfg_wp[BIT_LVP]);
	endproperty
	a_lvp_keep: assert property (p_lvp_keep) else $error("low voltage enable cleared in session");

	property p_guard_now;
		quiet && hit_cp && cfg_unlock && !reg_wdata[BIT_PROG_GUARD] |=> ##1 program_guard_on;
	endproperty
	a_guard_now: assert property (p_guard_now) else $error("program guard late");

	property p_part_read;
		reg_rd && (reg_addr == ADDR_PART_ID) |=> reg_rdata[13:12] == ID_TOP_PART;
	endproperty
	a_part_read: assert property (p_part_read) else $error("part id top bits wrong");

	property p_rev_read;
		reg_rd && (reg_addr == ADDR_REVISION) |=> (reg_rdata[13:12] == ID_TOP_REV) && (reg_rdata[11:6] == MAJOR_REV);
	endproperty
	a_rev_read: assert property (p_rev_read) else $error("revision word wrong");

	property p_err_flag;
		nvm_wr_refused |-> write_error_flag;
	endproperty
	a_err_flag: assert property (p_err_flag) else $error("refusal without error flag");

	property p_exec_saf;
		fetch_req && !act_saf_en_n && (fetch_addr >= SAF_BASE) && (fetch_addr <= PROG_LAST) |=> exec_violation;
	endproperty
	a_exec_saf: assert property (p_exec_saf) else $error("storage area fetch not flagged");

	property p_hold_part;
		!load_pending |=> $stable(act_size) && $stable(act_boot_en_n) && $stable(act_saf_en_n);
	endproperty
	a_hold_part: assert property (p_hold_part) else $error("partition moved without reset");

	c_grant:   cover property (nvm_wr_req ##1 nvm_wr_grant);
	c_refuse:  cover property (nvm_wr_req ##1 nvm_wr_refused);
	c_exec:    cover property (exec_violation);
	c_erase:   cover property (program_guard_on ##1 bulk_erase ##2 !program_guard_on);

endmodule // fppc_core

// [verification/flash_partition_protect_config_tb_top.sv]
`timescale 1ns/100ps
module flash_partition_protect_config_tb_top;
	import fppc_pkg::*;

	// ****************************************
	// Signals
	// ****************************************
	typedef struct packed {logic [15:0] wp; logic [15:0] cp; logic [15:0] bend; logic [3:0] f;} fppc_row_t;
	logic        clk_sys, reset_n, reg_wr, reg_rd, bulk_erase, lvp_session, fetch_req;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, fetch_addr, boot_end_addr, wp_word, cp_word, wp_img, cp_img;
	logic [15:0] nvm_wr_addr;
	logic        nvm_wr_req, nvm_wr_grant, nvm_wr_refused, exec_violation, write_error_flag;
	logic        boot_region_active, storage_area_active, program_guard_on, eeprom_guard_on;
	int          failures, tests_run, cycles;
	fppc_row_t   rows [11] = '{'{16'h2F9F, 16'h0003, 16'h0000, 4'h0}, '{16'h2F97, 16'h0003, 16'h01FF, 4'h8},
		'{16'h2F96, 16'h0003, 16'h03FF, 4'h8}, '{16'h2F95, 16'h0003, 16'h07FF, 4'h8},
		'{16'h2F94, 16'h0003, 16'h0FFF, 4'h8}, '{16'h2F93, 16'h0003, 16'h0FFF, 4'h8},
		'{16'h2F92, 16'h0003, 16'h0FFF, 4'h8}, '{16'h2F91, 16'h0003, 16'h0FFF, 4'h8},
		'{16'h2F90, 16'h0003, 16'h0FFF, 4'h8}, '{16'h2F8F, 16'h0002, 16'h0000, 4'h6},
		'{16'h2F87, 16'h0001, 16'h01FF, 4'hD}};
	logic [15:0] wr_addrs [5] = '{16'h0100, 16'h0500, 16'h1F90, 16'h8000, 16'hF010};

	// ****************************************
	// Instances
	// ****************************************
	fppc_core DUT (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_wp_image(wp_img), .cfg_cp_image(cp_img),
		.bulk_erase(bulk_erase), .lvp_session(lvp_session), .nvm_wr_req(nvm_wr_req), .nvm_wr_addr(nvm_wr_addr),
		.nvm_wr_grant(nvm_wr_grant), .nvm_wr_refused(nvm_wr_refused), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .exec_violation(exec_violation), .write_error_flag(write_error_flag),
		.boot_region_active(boot_region_active), .boot_end_addr(boot_end_addr),
		.storage_area_active(storage_area_active), .program_guard_on(program_guard_on),
		.eeprom_guard_on(eeprom_guard_on));
	fppc_nvm_model u_model (.clk_sys(clk_sys), .wp_word(wp_word), .cp_word(cp_word), .cfg_wp_image(wp_img),
		.cfg_cp_image(cp_img), .nvm_wr_req(nvm_wr_req), .nvm_wr_addr(nvm_wr_addr), .nvm_wr_grant(nvm_wr_grant),
		.nvm_wr_refused(nvm_wr_refused));

	// ****************************************
	// Clock, timeout and tasks
	// ****************************************
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// Whole run is well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (failures == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Reset with new stored words; policy outputs settle at the second edge
	task automatic do_reset(input logic [15:0] w, input logic [15:0] c);
		@(posedge clk_sys);
		reset_n <= 1'b0;
		wp_word <= w;
		cp_word <= c;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask

	task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask

	task automatic reg_read(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask

	task automatic nvm(input logic [15:0] a, input logic [1:0] exp);
		logic [1:0] ans;
		u_model.request(a, ans);
		chk({14'h0000, ans}, {14'h0000, exp});
	endtask

	task automatic fetch(input logic [15:0] a, input logic exp);
		@(posedge clk_sys);
		fetch_req  <= 1'b1;
		fetch_addr <= a;
		@(posedge clk_sys);
		fetch_req  <= 1'b0;
		#1 chk({15'h0000, exec_violation}, {15'h0000, exp});
	endtask

	// Grant 10, refusal 01; unmapped space always refused
	task automatic wr_pass(input logic [1:0] exp);
		for (int i = 0; i < 5; i++)
			nvm(wr_addrs[i], exp);
		nvm(16'h4000, 2'b01);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{reset_n, reg_wr, reg_rd, bulk_erase, lvp_session, fetch_req} = 6'h00;
		{reg_addr, reg_wdata, fetch_addr} = 48'h0;
		{wp_word, cp_word} = 32'h2F9F_0003;
		{failures, tests_run, cycles} = 96'h0;
		// Partition decode table
		foreach (rows[i]) begin
			do_reset(rows[i].wp, rows[i].cp);
			chk(boot_end_addr, rows[i].bend);
			chk({12'h000, boot_region_active, storage_area_active, program_guard_on, eeprom_guard_on},
				{12'h000, rows[i].f});
			reg_read(ADDR_CFG_WP, rows[i].wp);
		end
		// Write permission, unlocked then locked
		do_reset(16'h2F87, 16'h0003);
		wr_pass(2'b10);
		fetch(16'h1F90, 1'b1);
		fetch(16'h1F7F, 1'b0);
		reg_read(ADDR_STATUS, 16'h0001);
		reg_write(ADDR_STATUS, 16'h0001);
		reg_read(ADDR_STATUS, 16'h0000);
		do_reset(16'h2007, 16'h0003);
		wr_pass(2'b01);
		chk({15'h0000, write_error_flag}, 16'h0001);
		// Locks on disabled regions do not apply
		do_reset(16'h269F, 16'h0003);
		nvm(16'h0100, 2'b10);
		nvm(16'h1F90, 2'b10);
		fetch(16'h1F90, 1'b0);
		// Sticky locks, size field, low voltage bit
		do_reset(16'h2F9F, 16'h0003);
		reg_write(ADDR_CFG_WP, 16'h2F1F);
		nvm(16'h0500, 2'b01);
		reg_write(ADDR_CFG_WP, 16'h2F9F);
		reg_read(ADDR_CFG_WP, 16'h2F1F);
		reg_write(ADDR_CFG_WP, 16'h2F15);
		reg_read(ADDR_CFG_WP, 16'h2F15);
		reg_write(ADDR_CFG_WP, 16'h2F12);
		reg_read(ADDR_CFG_WP, 16'h2F15);
		chk({15'h0000, boot_region_active}, 16'h0000);
		@(posedge clk_sys);
		lvp_session <= 1'b1;
		repeat (3) @(posedge clk_sys);
		reg_read(ADDR_STATUS, 16'h0003);
		reg_write(ADDR_CFG_WP, 16'h0F15);
		reg_read(ADDR_CFG_WP, 16'h2F15);
		@(posedge clk_sys);
		lvp_session <= 1'b0;
		repeat (3) @(posedge clk_sys);
		reg_write(ADDR_CFG_WP, 16'h0F15);
		reg_read(ADDR_CFG_WP, 16'h0F15);
		// Code guard: immediate and sticky, written after the partition word
		reg_write(ADDR_CFG_CP, 16'h0002);
		@(posedge clk_sys);
		#1 chk({15'h0000, program_guard_on}, 16'h0001);
		reg_write(ADDR_CFG_CP, 16'h0003);
		reg_read(ADDR_CFG_CP, 16'h0002);
		// Config lock refuses the whole word and flags it; lock comes from the stored word
		do_reset(16'h2D9F, 16'h0002);
		reg_write(ADDR_CFG_CP, 16'h0000);
		reg_read(ADDR_CFG_CP, 16'h0002);
		reg_read(ADDR_STATUS, 16'h0001);
		chk({15'h0000, eeprom_guard_on}, 16'h0000);
		// Identification is read only; unmapped reads give zero
		reg_read(ADDR_PART_ID, 16'h3A5C);
		reg_write(ADDR_PART_ID, 16'h0000);
		reg_read(ADDR_PART_ID, 16'h3A5C);
		reg_read(ADDR_REVISION, 16'h2042);
		reg_read(16'h8100, 16'h0000);
		// Only a bulk erase lifts protection
		@(posedge clk_sys);
		bulk_erase <= 1'b1;
		@(posedge clk_sys);
		bulk_erase <= 1'b0;
		reg_read(ADDR_CFG_WP, CFG_WP_ERASED);
		reg_read(ADDR_CFG_CP, CFG_CP_ERASED);
		chk({15'h0000, program_guard_on}, 16'h0000);
		finish_test();
	end
endmodule // flash_partition_protect_config_tb_top

// [verification/fppc_nvm_model.sv]
`timescale 1ns/100ps
// ****************************************
// Programmer and stored configuration model
// ****************************************
module fppc_nvm_model (
	input  wire logic                        clk_sys,
	input  wire logic [fppc_pkg::DATA_W-1:0] wp_word,
	input  wire logic [fppc_pkg::DATA_W-1:0] cp_word,
	output logic      [fppc_pkg::DATA_W-1:0] cfg_wp_image,
	output logic      [fppc_pkg::DATA_W-1:0] cfg_cp_image,
	output logic                             nvm_wr_req,
	output logic      [fppc_pkg::ADDR_W-1:0] nvm_wr_addr,
	input  wire logic                        nvm_wr_grant,
	input  wire logic                        nvm_wr_refused
);
	import fppc_pkg::*;

	// Stored words as held by the array, sampled by the block after reset
	assign cfg_wp_image = wp_word;
	assign cfg_cp_image = cp_word;

	initial begin
		nvm_wr_req  = 1'b0;
		nvm_wr_addr = 16'h0000;
	end

	// One write request; answer taken in the cycle after the taking edge
	// Address is inverted after release so a stale value never matches the requested address
	task automatic request(input logic [ADDR_W-1:0] a, output logic [1:0] ans);
		@(posedge clk_sys);
		nvm_wr_req  <= 1'b1;
		nvm_wr_addr <= a;
		@(posedge clk_sys);
		nvm_wr_req  <= 1'b0;
		nvm_wr_addr <= ~a;
		#1 ans = {nvm_wr_grant, nvm_wr_refused};
	endtask
endmodule // fppc_nvm_model
